// file: design/cpi_top.sv
// Codec serial port: I2S modes 4/5, AIC pulse mode, AHB-Lite registers
`default_nettype none
module cpi_top
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic [31:0] hrdata,
    output var  logic        hreadyout,
    output var  logic        hresp,
    // Codec pins
    input  wire logic        frame_sync_pin_i,
    output var  logic        frame_sync_pin_o,
    output var  logic        frame_sync_pin_oe,
    output var  logic        serial_clock_pin_o,
    output var  logic        serial_out_pin_o,
    input  wire logic        serial_in_pin_i,
    output var  logic        codec_reset_pin_o,
    input  wire logic        secondary_channel_pin_i,
    output var  logic        secondary_channel_pin_o,
    output var  logic        secondary_channel_pin_oe
);
    import cpi_pkg::*;

    logic [15:0]  ctrl_q;
    logic [15:0]  clkdiv_q;
    cpi_sample_t  tx_q [2];
    cpi_sample_t  rx_q [4];
    logic [3:0]   rx_new_q;
    logic         ap_wr_q;
    logic [7:0]   ap_addr_q;
    logic [1:0]   fs_sync_q;
    logic [1:0]   sin_sync_q;
    logic [1:0]   sch_sync_q;
    cpi_sample_t  tx_sh_q;
    logic         sdo_q;
    cpi_sample_t  rx_sh_q [2];

    logic [2:0]   mode;
    logic         is_i2s4;
    logic         is_i2s5;
    logic         is_aic;
    logic         is_i2s;
    logic         aic_slave;
    logic         bulk_act;
    logic         mark_act;
    cpi_sample_t  mask;
    logic [3:0]   in_slot_en;
    logic [1:0]   out_slot_en;
    logic         ap_valid;
    logic [3:0]   rx_set;
    logic [3:0]   rx_clr;
    logic [31:0]  rd_mux;

    logic         p_sclk;
    logic [5:0]   p_cnt;
    logic         p_fall;
    logic         p_rise;
    logic         r_sclk;
    logic [5:0]   r_cnt;
    logic         r_fall;
    logic         r_rise;
    logic         p_resync;
    logic [4:0]   p_pos;

    logic [1:0]   ln_fall;
    logic [1:0]   ln_rise;
    logic [5:0]   ln_cnt [2];
    logic [1:0]   ln_din;
    logic [1:0]   ln_en;

    assign mode        = ctrl_q[CTRL_MODE_LSB +: 3];
    assign is_i2s4     = (mode == MODE_I2S4);
    assign is_i2s5     = (mode == MODE_I2S5);
    assign is_aic      = (mode == MODE_AIC);
    assign is_i2s      = is_i2s4 | is_i2s5;
    assign aic_slave   = ctrl_q[CTRL_AIC_SLAVE];
    assign in_slot_en  = ctrl_q[CTRL_IN_SLOT +: 4];
    assign out_slot_en = ctrl_q[CTRL_OUT_SLOT +: 2];
    assign p_pos       = p_cnt[4:0];
    // AIC words are 16 bits; I2S takes the programmed sample width
    assign mask = cpi_wl_mask(is_aic ? WL_AIC : ctrl_q[CTRL_WL_LSB +: 2]);

    // Bulk OUT is refused in I2S and AIC modes
    assign bulk_act = ctrl_q[CTRL_BULK_EN] && (mode <= MODE_AC97_2);
    // Marking is only meaningful while bulk is live
    assign mark_act = bulk_act && ctrl_q[CTRL_MARK_EN];

    // Pin synchronisers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            fs_sync_q  <= 2'b00;
            sin_sync_q <= 2'b00;
            sch_sync_q <= 2'b00;
        end
        else
        begin
            fs_sync_q  <= {fs_sync_q[0], frame_sync_pin_i};
            sin_sync_q <= {sin_sync_q[0], serial_in_pin_i};
            sch_sync_q <= {sch_sync_q[0], secondary_channel_pin_i};
        end
    end

    // AIC master: the codec's one-clock sync pulse realigns the frame
    assign p_resync = is_aic && !aic_slave && p_rise && fs_sync_q[1];

    cpi_frame_gen u_play_gen
    (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .en       (is_i2s | is_aic),
        .resync   (p_resync),
        .half_div (clkdiv_q[7:0]),
        .sclk_q   (p_sclk),
        .bitcnt_q (p_cnt),
        .fall_q   (p_fall),
        .rise_q   (p_rise)
    );

    // Independent record timing only exists in mode 5
    cpi_frame_gen u_rec_gen
    (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .en       (is_i2s5),
        .resync   (1'b0),
        .half_div (clkdiv_q[15:8]),
        .sclk_q   (r_sclk),
        .bitcnt_q (r_cnt),
        .fall_q   (r_fall),
        .rise_q   (r_rise)
    );

    // Transmit lane: load at slot start, MSB one clock later
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tx_sh_q <= '0;
            sdo_q   <= 1'b0;
        end
        else if (p_fall)
        begin
            if (p_pos == 5'd0)
            begin
                // AIC carries one word per frame, in the left half only
                if (out_slot_en[p_cnt[5]] && !(is_aic && p_cnt[5]))
                    tx_sh_q <= tx_q[p_cnt[5]] & mask;
                else
                    tx_sh_q <= '0;
                sdo_q <= 1'b0;
            end
            else if (p_pos <= POS_LSB24)
            begin
                sdo_q   <= tx_sh_q[SAMPLE_W-1];
                tx_sh_q <= {tx_sh_q[SAMPLE_W-2:0], 1'b0};
            end
            else
                sdo_q <= 1'b0;
        end
    end

    // Receive lanes: lane 0 is the serial_in pin, lane 1 the secondary pin
    assign ln_fall[0] = is_i2s5 ? r_fall : p_fall;
    assign ln_rise[0] = is_i2s5 ? r_rise : p_rise;
    assign ln_cnt[0]  = is_i2s5 ? r_cnt : p_cnt;
    assign ln_din[0]  = sin_sync_q[1];
    assign ln_en[0]   = is_i2s | is_aic;
    assign ln_fall[1] = p_fall;
    assign ln_rise[1] = p_rise;
    assign ln_cnt[1]  = p_cnt;
    assign ln_din[1]  = sch_sync_q[1];
    assign ln_en[1]   = is_i2s4;

    always_comb
    begin
        rx_set = 4'h0;
        for (int i = 0; i < 2; i++)
        begin
            // Slot just ended is the one opposite the new LRCK level
            if (ln_en[i] && ln_fall[i] && ln_cnt[i][4:0] == 5'd0
                && in_slot_en[{i[0], ~ln_cnt[i][5]}]
                && !(is_aic && !ln_cnt[i][5]))
                rx_set[{i[0], ~ln_cnt[i][5]}] = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rx_sh_q <= '{default: '0};
            rx_q    <= '{default: '0};
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (ln_fall[i] && ln_cnt[i][4:0] == 5'd0)
                    rx_sh_q[i] <= '0;
                else if (ln_rise[i] && ln_cnt[i][4:0] >= POS_MSB
                         && ln_cnt[i][4:0] <= POS_LSB24)
                    rx_sh_q[i] <= {rx_sh_q[i][SAMPLE_W-2:0], ln_din[i]};
            end
            for (int s = 0; s < 4; s++)
            begin
                if (rx_set[s])
                    rx_q[s] <= rx_sh_q[s[1]] & mask;
            end
        end
    end

    // Pin drivers, registered so every pin moves on the same edge
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            frame_sync_pin_o         <= 1'b0;
            frame_sync_pin_oe        <= 1'b0;
            serial_clock_pin_o       <= 1'b0;
            serial_out_pin_o         <= 1'b0;
            codec_reset_pin_o        <= 1'b0;
            secondary_channel_pin_o  <= 1'b0;
            secondary_channel_pin_oe <= 1'b0;
        end
        else
        begin
            serial_clock_pin_o <= p_sclk;
            serial_out_pin_o   <= sdo_q;
            if (is_i2s)
                frame_sync_pin_o <= p_cnt[5];
            else
                frame_sync_pin_o <= (p_cnt == 6'd0);
            frame_sync_pin_oe <= is_i2s || (is_aic && aic_slave);
            if (is_i2s5)
                codec_reset_pin_o <= r_sclk;
            else
                codec_reset_pin_o <= ctrl_q[CTRL_CODEC_RST];
            if (is_i2s5)
                secondary_channel_pin_o <= r_cnt[5];
            else
                secondary_channel_pin_o <= is_aic && ctrl_q[CTRL_SEC_REQ];
            secondary_channel_pin_oe <= is_i2s5 || is_aic;
        end
    end

    // AHB-Lite slave, zero wait states
    assign ap_valid = hsel && htrans[1] && hready;

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        case (haddr[7:0])
            ADDR_CTRL:          rd_mux = {16'h0000, ctrl_q};
            ADDR_CLKDIV:        rd_mux = {16'h0000, clkdiv_q};
            ADDR_TX_LEFT:       rd_mux = {8'h00, tx_q[0]};
            ADDR_TX_RIGHT:      rd_mux = {8'h00, tx_q[1]};
            ADDR_RX_BASE:       rd_mux = {8'h00, rx_q[0]};
            ADDR_RX_BASE + 8'h04: rd_mux = {8'h00, rx_q[1]};
            ADDR_RX_BASE + 8'h08: rd_mux = {8'h00, rx_q[2]};
            ADDR_RX_BASE + 8'h0c: rd_mux = {8'h00, rx_q[3]};
            ADDR_STATUS:
            begin
                rd_mux[STAT_RX_NEW +: 4] = rx_new_q;
                rd_mux[STAT_BULK_ACT]    = bulk_act;
                rd_mux[STAT_MARK_ACT]    = mark_act;
                rd_mux[STAT_LRCK]        = p_cnt[5];
            end
            default:            rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ap_wr_q   <= 1'b0;
            ap_addr_q <= 8'h00;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end
        else
        begin
            ap_wr_q   <= ap_valid && hwrite;
            ap_addr_q <= haddr[7:0];
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (ap_valid && !hwrite)
                hrdata <= rd_mux;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_q   <= CTRL_RESET;
            clkdiv_q <= CLKDIV_RESET;
            tx_q     <= '{default: '0};
        end
        else if (ap_wr_q)
        begin
            case (ap_addr_q)
                ADDR_CTRL:     ctrl_q   <= hwdata[15:0];
                ADDR_CLKDIV:   clkdiv_q <= hwdata[15:0];
                ADDR_TX_LEFT:  tx_q[0]  <= hwdata[SAMPLE_W-1:0];
                ADDR_TX_RIGHT: tx_q[1]  <= hwdata[SAMPLE_W-1:0];
                default:       ctrl_q   <= ctrl_q;
            endcase
        end
    end

    // Receive flags: write one to clear, a new sample wins over the clear
    assign rx_clr = (ap_wr_q && ap_addr_q == ADDR_STATUS)
                  ? hwdata[STAT_RX_NEW +: 4] : 4'h0;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rx_new_q <= 4'h0;
        else
            rx_new_q <= (rx_new_q & ~rx_clr) | rx_set;
    end
endmodule : cpi_top
`default_nettype wire

// file: design/cpi_pkg.sv
// Constants, register map and helpers for the codec serial port
`default_nettype none
// How it works
// - Mode 4: one output, primary and secondary inputs sharing one LRCK and SCLK.
// - Mode 5: output and secondary input each get their own frame sync and clock.
// - Two slots per frame framed by LRCK; slot 0 left, slot 1 right.
// - Each slot is 32 SCLK cycles; LRCK period is 64 SCLK cycles.
// - LRCK low for the left slot, high for the right slot, 50% duty.
// - LRCK and output bits change on SCLK fall; inputs sampled on SCLK rise.
// - The MSB starts one SCLK cycle after each LRCK transition.
// - 24-bit shift register per serial line; unused bits are zero.
// - Mode 4 DMA slots: out L/R 0/1, primary in 0/1, secondary in 2/3.
// - Out channel uses slot enables 0-1, input channel slot enables 0-3.
// - AIC supports pulse format only: frame sync lasts one serial clock.
// - AIC master option takes codec frame sync; slave option drives it.
// - AIC secondary requests only via active-high pin, never via data LSB.
// - Bulk OUT only in AC'97 or general-purpose modes, never I2S or AIC.
// - With marking enabled, validity is marked by sync omission or tag clearing; the code only reports marking in STAT_MARK_ACT.
package cpi_pkg;
    // Register byte offsets
    localparam logic [7:0]  ADDR_CTRL      = 8'h00;
    localparam logic [7:0]  ADDR_CLKDIV    = 8'h04;
    localparam logic [7:0]  ADDR_TX_LEFT   = 8'h08;
    localparam logic [7:0]  ADDR_TX_RIGHT  = 8'h0c;
    localparam logic [7:0]  ADDR_RX_BASE   = 8'h10;
    localparam logic [7:0]  ADDR_STATUS    = 8'h20;
    // Control fields
    localparam int          CTRL_MODE_LSB  = 0;
    localparam int          CTRL_WL_LSB    = 3;
    localparam int          CTRL_AIC_SLAVE = 5;
    localparam int          CTRL_CODEC_RST = 6;
    localparam int          CTRL_SEC_REQ   = 7;
    localparam int          CTRL_MARK_EN   = 8;
    localparam int          CTRL_BULK_EN   = 9;
    localparam int          CTRL_IN_SLOT   = 10;
    localparam int          CTRL_OUT_SLOT  = 14;
    localparam logic [15:0] CTRL_RESET     = 16'hfc04;
    localparam logic [15:0] CLKDIV_RESET   = 16'h0707;
    // Status fields
    localparam int          STAT_RX_NEW    = 0;
    localparam int          STAT_BULK_ACT  = 4;
    localparam int          STAT_MARK_ACT  = 5;
    localparam int          STAT_LRCK      = 6;
    // Port modes
    localparam logic [2:0]  MODE_GP        = 3'h0;
    localparam logic [2:0]  MODE_AC97_2    = 3'h3;
    localparam logic [2:0]  MODE_I2S4      = 3'h4;
    localparam logic [2:0]  MODE_I2S5      = 3'h5;
    localparam logic [2:0]  MODE_AIC       = 3'h6;
    // Frame timing
    localparam logic [4:0]  POS_MSB        = 5'd1;
    localparam logic [4:0]  POS_LSB24      = 5'd24;
    localparam logic [5:0]  AIC_RESYNC_POS = 6'd1;
    localparam int          SAMPLE_W       = 24;
    localparam logic [1:0]  WL_AIC         = 2'h0;

    typedef logic [SAMPLE_W-1:0] cpi_sample_t;

    // Keeps the top bits of a left-justified 24-bit sample
    function automatic cpi_sample_t cpi_wl_mask(input logic [1:0] wl);
        case (wl)
            2'h0:    cpi_wl_mask = 24'hffff00;
            2'h1:    cpi_wl_mask = 24'hffffc0;
            2'h2:    cpi_wl_mask = 24'hfffff0;
            default: cpi_wl_mask = 24'hffffff;
        endcase
    endfunction : cpi_wl_mask
endpackage : cpi_pkg
`default_nettype wire

// file: design/cpi_frame_gen.sv
// Bit clock and 64-bit frame counter generator for one serial stream
`default_nettype none
module cpi_frame_gen
(
    // Clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // Control
    input  wire logic       en,
    input  wire logic       resync,
    input  wire logic [7:0] half_div,
    // Timing
    output var  logic       sclk_q,
    output var  logic [5:0] bitcnt_q,
    output var  logic       fall_q,
    output var  logic       rise_q
);
    import cpi_pkg::*;

    logic [7:0] div_q;
    logic       resync_q;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            resync_q <= 1'b0;
        else if (!en || fall_q)
            resync_q <= 1'b0;
        else if (resync)
            resync_q <= 1'b1;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            div_q    <= 8'h00;
            sclk_q   <= 1'b0;
            bitcnt_q <= 6'h3f;
            fall_q   <= 1'b0;
            rise_q   <= 1'b0;
        end
        else if (!en)
        begin
            div_q    <= 8'h00;
            sclk_q   <= 1'b0;
            bitcnt_q <= 6'h3f;
            fall_q   <= 1'b0;
            rise_q   <= 1'b0;
        end
        else if (div_q >= half_div)
        begin
            div_q  <= 8'h00;
            sclk_q <= ~sclk_q;
            fall_q <= sclk_q;
            rise_q <= ~sclk_q;
            // Frame position and LRCK move only on the falling edge
            if (sclk_q)
                bitcnt_q <= resync_q ? AIC_RESYNC_POS : bitcnt_q + 6'd1;
        end
        else
        begin
            div_q  <= div_q + 8'd1;
            fall_q <= 1'b0;
            rise_q <= 1'b0;
        end
    end
endmodule : cpi_frame_gen
`default_nettype wire

// file: tb/cpi_top_assertions.sv
// Port-level concurrent checks for the codec serial port
`default_nettype none
module cpi_top_assertions
(
    // Clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // Bus
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Codec pins
    input wire logic        frame_sync_pin_o,
    input wire logic        frame_sync_pin_oe,
    input wire logic        serial_clock_pin_o,
    input wire logic        serial_out_pin_o,
    input wire logic        codec_reset_pin_o,
    input wire logic        secondary_channel_pin_o,
    input wire logic        secondary_channel_pin_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       rd_q, ck_q, fell_q, fs_q, ok_q, moch_q, rc_q;
    logic [1:0] oe_q;
    logic [5:0] cnt_q;
    logic [4:0] idle_q;
    wire logic  fell   = ck_q & ~serial_clock_pin_o;
    wire logic  fs_chg = frame_sync_pin_o ^ fs_q;
    wire logic  moch   = {frame_sync_pin_oe, secondary_channel_pin_oe} != oe_q;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // An enable change marks a mode switch, so a period spanning one is not judged
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            {rd_q, ck_q, fell_q, fs_q, ok_q, moch_q, rc_q, oe_q, cnt_q, idle_q} <= '0;
        else
        begin
            rd_q   <= hsel & htrans[1] & ~hwrite & hready;
            ck_q   <= serial_clock_pin_o;
            fell_q <= fell;
            fs_q   <= frame_sync_pin_o;
            oe_q   <= {frame_sync_pin_oe, secondary_channel_pin_oe};
            moch_q <= moch;
            ok_q   <= (moch | moch_q) ? 1'b0 : (fs_chg ? 1'b1 : ok_q);
            cnt_q  <= fs_chg ? 6'h0 : cnt_q + {5'h0, fell};
            rc_q   <= codec_reset_pin_o;
            idle_q <= (rc_q != codec_reset_pin_o) ? 5'h0 : idle_q + {4'h0, idle_q != 5'h1f};
        end
    end
    sequence sync_edge;
        fs_chg && frame_sync_pin_oe && !moch && !moch_q;
    endsequence
    sequence settled_edge;
        sync_edge ##0 ok_q;
    endsequence
    hresp_okay_a: assert property (!hresp)
        else $error("error response on the bus");
    ready_zero_wait_a: assert property ($past(hresetn) |-> hreadyout)
        else $error("wait state inserted");
    rd_hold_a: assert property ($changed(hrdata) |-> rd_q)
        else $error("read data changed outside a read");
    lrck_on_fall_a: assert property (sync_edge |-> fell)
        else $error("frame sync moved off a clock fall");
    out_on_fall_a: assert property ($changed(serial_out_pin_o) && !moch && !moch_q
        |-> fell || fell_q) else $error("data moved off a clock fall");
    lrck_period_a: assert property (settled_edge ##0 !secondary_channel_pin_oe
        |-> cnt_q == 6'd31) else $error("slot not 32 clocks");
    sync_width_a: assert property (settled_edge ##0 !frame_sync_pin_o
        |-> cnt_q inside {6'd0, 6'd31}) else $error("frame sync high time wrong");
    rec_sync_a: assert property ($changed(secondary_channel_pin_o) && !moch
        && secondary_channel_pin_oe && idle_q < 5'd16 |-> $fell(codec_reset_pin_o))
        else $error("record sync moved off a record clock fall");
endmodule : cpi_top_assertions
bind cpi_top cpi_top_assertions u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .frame_sync_pin_o(frame_sync_pin_o), .frame_sync_pin_oe(frame_sync_pin_oe),
    .serial_clock_pin_o(serial_clock_pin_o), .serial_out_pin_o(serial_out_pin_o),
    .codec_reset_pin_o(codec_reset_pin_o), .secondary_channel_pin_o(secondary_channel_pin_o),
    .secondary_channel_pin_oe(secondary_channel_pin_oe));
`default_nettype wire

// file: tb/cpi_codec_model.sv
// Behavioural codec: serial source and sink, frame sync source when master
`default_nettype none
module cpi_codec_model
(
    // Serial timing
    input  wire logic        sck,
    input  wire logic        fs,
    input  wire logic        aic,
    input  wire logic        master,
    // Data
    input  wire logic        sdo,
    input  wire logic [23:0] tx_l,
    input  wire logic [23:0] tx_r,
    output var  logic        sdi,
    output var  logic        fs_out,
    output var  logic [23:0] rx_l,
    output var  logic [23:0] rx_r
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [5:0]  pos_q, cnt_q;
    logic [23:0] sh_q;
    logic        fs_q, slot_q;
    initial {pos_q, cnt_q, sh_q, fs_q, slot_q, sdi, fs_out, rx_l, rx_r} = '0;
    always @(negedge sck)
    begin
        #1 cnt_q = cnt_q + 6'h1;
        if (master ? cnt_q == 6'h0 : (aic ? fs && !fs_q : fs != fs_q))
            pos_q = 6'h0;
        else
            pos_q = pos_q + 6'h1;
        slot_q = aic ? 1'b0 : fs;
        fs_q = fs;
        fs_out <= master && cnt_q == 6'h0;
        // Outside the word the line toggles so a stale bit cannot pass
        if (pos_q >= 1 && pos_q <= 24)
            sdi <= slot_q ? tx_r[24-pos_q] : tx_l[24-pos_q];
        else
            sdi <= pos_q[0];
    end
    always @(posedge sck)
    begin
        if (pos_q >= 1 && pos_q <= 24)
        begin
            sh_q[24-pos_q] = sdo;
            if (pos_q == 24 && slot_q)
                rx_r <= sh_q;
            else if (pos_q == 24)
                rx_l <= sh_q;
        end
    end
endmodule : cpi_codec_model
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the codec serial port
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import cpi_pkg::*;
    typedef struct packed {
        logic [2:0]  mode;
        logic [1:0]  wl;
        logic [23:0] txl, txr, inl, inr, in2l, in2r;
    } cpi_tb_row_t;
    logic        hclk, hresetn, hsel, hwrite, m5, aic, master;
    logic [31:0] haddr, hwdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [23:0] inl, inr, in2l, in2r, k;
    wire logic   hready, hresp, fs_o, fs_oe, sclk, sdo, crst, sec_o, sec_oe, a_sdi, b_sdi, a_fs;
    wire logic [31:0] hrdata;
    wire logic [23:0] got_l, got_r;
    wire logic   fs_w  = fs_oe ? fs_o : a_fs;
    wire logic   sec_w = sec_oe ? sec_o : b_sdi;
    int          mismatches, check_count, cycles;
    cpi_tb_row_t rows [5];
    cpi_tb_row_t r;
    cpi_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp), .frame_sync_pin_i(fs_w), .frame_sync_pin_o(fs_o),
        .frame_sync_pin_oe(fs_oe), .serial_clock_pin_o(sclk), .serial_out_pin_o(sdo),
        .serial_in_pin_i(m5 ? b_sdi : a_sdi), .codec_reset_pin_o(crst),
        .secondary_channel_pin_i(sec_w), .secondary_channel_pin_o(sec_o),
        .secondary_channel_pin_oe(sec_oe));
    cpi_codec_model cod_a (.sck(sclk), .fs(fs_w), .aic(aic), .master(master), .sdo(sdo),
        .tx_l(inl), .tx_r(inr), .sdi(a_sdi), .fs_out(a_fs), .rx_l(got_l), .rx_r(got_r));
    cpi_codec_model cod_b (.sck(m5 ? crst : sclk), .fs(m5 ? sec_o : fs_w), .aic(aic),
        .master(master), .sdo(1'b0), .tx_l(in2l), .tx_r(in2r), .sdi(b_sdi), .fs_out(),
        .rx_l(), .rx_r());
    initial
    begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop
    // Cuts a hang short; a full run is about 16500 cycles
    always @(posedge hclk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            mismatches++;
            report_and_stop();
        end
    end
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_reg
    task automatic chk_pin(input logic got, input logic exp);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected pin level at %0t: got %b expected %b", $time, got, exp);
        end
    endtask : chk_pin
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : ahb
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        chk_reg(rd, exp);
    endtask : rd_chk
    // Idle in between so every configuration starts from fresh frames
    task automatic run_row(input cpi_tb_row_t x, input logic [10:0] hi);
        ahb(1'b1, ADDR_CTRL, 32'h7);
        m5 <= x.mode == MODE_I2S5;
        {inl, inr, in2l, in2r} <= {x.inl, x.inr, x.in2l, x.in2r};
        ahb(1'b1, ADDR_TX_LEFT, {8'h0, x.txl});
        ahb(1'b1, ADDR_TX_RIGHT, {8'h0, x.txr});
        ahb(1'b1, ADDR_CTRL, {16'h0, hi, x.wl, x.mode});
        repeat (2048) @(posedge hclk);
    endtask : run_row
    function automatic logic [23:0] msk(input logic [1:0] wl);
        return 24'hffffff << (wl == 2'h3 ? 0 : 8 - 2 * wl);
    endfunction : msk
    initial
    begin
        {hresetn, hsel, hwrite, m5, aic, master} = '0;
        {haddr, hwdata, htrans} = '0;
        hsize = 3'h2;
        {inl, inr, in2l, in2r} = '0;
        rows[0] = '{MODE_I2S4, 2'h0, 24'ha5c3e1, 24'h1e2d3f, 24'h9b8a79, 24'h687f4e,
            24'hc1d2e3, 24'h2f3e4d};
        rows[1] = '{MODE_I2S4, 2'h1, 24'h5a3c7f, 24'he1d2c3, 24'h7fffff, 24'h800001,
            24'h3ff0ff, 24'hc00f0f};
        rows[2] = '{MODE_I2S4, 2'h2, 24'hfedcbb, 24'h012345, 24'h8f8f8f, 24'h71717f,
            24'h0ff00f, 24'hf00ff1};
        rows[3] = '{MODE_I2S4, 2'h3, 24'h800001, 24'h7ffffe, 24'h123457, 24'hedcba9,
            24'h55aa55, 24'haa55ab};
        rows[4] = '{MODE_I2S5, 2'h3, 24'hc3a5e7, 24'h3c5a1b, 24'h0, 24'h0,
            24'h9e7d5b, 24'h61829f};
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk(ADDR_CTRL, {16'h0, CTRL_RESET});
        rd_chk(ADDR_CLKDIV, {16'h0, CLKDIV_RESET});
        ahb(1'b1, 8'h24, 32'hffffffff);
        rd_chk(8'h24, 32'h0);
        ahb(1'b1, ADDR_CLKDIV, 32'h0403);
        for (int i = 0; i < 5; i++)
        begin
            run_row(rows[i], {6'h3f, 5'h0});
            k = msk(rows[i].wl);
            chk_reg({8'h0, got_l}, {8'h0, rows[i].txl & k});
            chk_reg({8'h0, got_r}, {8'h0, rows[i].txr & k});
            rd_chk(ADDR_RX_BASE, {8'h0, (m5 ? rows[i].in2l : rows[i].inl) & k});
            rd_chk(ADDR_RX_BASE | 8'h04, {8'h0, (m5 ? rows[i].in2r : rows[i].inr) & k});
            if (!m5)
            begin
                rd_chk(ADDR_RX_BASE | 8'h08, {8'h0, rows[i].in2l & k});
                rd_chk(ADDR_RX_BASE | 8'h0c, {8'h0, rows[i].in2r & k});
            end
        end
        r = rows[3];
        r.inr = 24'h5a5a5a;
        r.in2r = 24'h3c3c3c;
        run_row(r, {2'b01, 4'b0101, 5'b00010});
        chk_reg({8'h0, got_r}, 32'h0);
        chk_pin(crst, 1'b1);
        chk_pin(sec_oe, 1'b0);
        rd_chk(ADDR_RX_BASE | 8'h04, {8'h0, rows[4].in2r});
        rd_chk(ADDR_RX_BASE | 8'h0c, {8'h0, rows[3].in2r});
        r = rows[0];
        r.mode = MODE_AIC;
        aic <= 1'b1;
        run_row(r, {6'h3f, 5'b00101});
        chk_pin(sec_o, 1'b1);
        chk_pin(fs_oe, 1'b1);
        chk_reg({8'h0, got_l}, {8'h0, r.txl & 24'hffff00});
        rd_chk(ADDR_RX_BASE, {8'h0, r.inl & 24'hffff00});
        master <= 1'b1;
        r.inl = 24'h13579b;
        run_row(r, {6'h3f, 5'b00000});
        chk_pin(fs_oe, 1'b0);
        chk_pin(sec_o, 1'b0);
        chk_reg({8'h0, got_l}, {8'h0, r.txl & 24'hffff00});
        rd_chk(ADDR_RX_BASE, {8'h0, r.inl & 24'hffff00});
        {aic, master} <= 2'b00;
        ahb(1'b1, ADDR_CTRL, 32'hff00);
        rd_chk(ADDR_CTRL, 32'hff00);
        ahb(1'b0, ADDR_STATUS, 32'h0);
        chk_reg(rd & 32'h3f, 32'h3f);
        ahb(1'b1, ADDR_CTRL, 32'hff04);
        rd_chk(ADDR_CTRL, 32'hff04);
        ahb(1'b0, ADDR_STATUS, 32'h0);
        chk_reg(rd & 32'h10, 32'h0);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk(ADDR_CTRL, {16'h0, CTRL_RESET});
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
